// ==== core/fptc_deliver.sv ====
// fixed-order trap delivery: firmware, then os handler, then user handler
`timescale 1ns/1ns
module fptc_deliver
  import fptc_pkg::*;
(
  input wire logic core_clk,
  input wire logic rstn,
  fptc_dlv_if.dst dlv,
  input wire logic fw_ack,
  input wire logic os_ack,
  input wire logic user_ack,
  output logic fw_trap,
  output logic os_trap,
  output logic user_trap,
  output logic [FPTC_CAUSE_W-1:0] trap_cause
);
  fptc_state_t state_q;

  // each layer is offered the trap only after the one before acknowledges
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= FPTC_ST_IDLE;
    end else begin
      unique case (state_q)
        FPTC_ST_IDLE: if (dlv.req) state_q <= FPTC_ST_FW;
        FPTC_ST_FW: if (fw_ack) state_q <= FPTC_ST_OS;
        FPTC_ST_OS: if (os_ack) state_q <= FPTC_ST_USER;
        FPTC_ST_USER: if (user_ack) state_q <= FPTC_ST_IDLE;
        default: state_q <= FPTC_ST_IDLE;
      endcase
    end
  end

  // cause is captured once and held through all three layers
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      trap_cause <= FPTC_CAUSE_RST;
    end else if (state_q == FPTC_ST_IDLE && dlv.req) begin
      trap_cause <= dlv.cause;
    end
  end

  assign fw_trap = (state_q == FPTC_ST_FW);
  assign os_trap = (state_q == FPTC_ST_OS);
  assign user_trap = (state_q == FPTC_ST_USER);
  assign dlv.busy = (state_q != FPTC_ST_IDLE);
endmodule : fptc_deliver

// ==== core/fptc_dlv_if.sv ====
// trap hand-off between the detector and the delivery sequencer
`timescale 1ns/1ns
interface fptc_dlv_if;
  import fptc_pkg::*;
  logic req;
  logic [FPTC_CAUSE_W-1:0] cause;
  logic busy;
  modport src (output req, output cause, input busy);
  modport dst (input req, input cause, output busy);
endinterface : fptc_dlv_if

// ==== core/fptc_pkg.sv ====
// shared constants and types for the floating-point trap control block
package fptc_pkg;

  // operation classes presented by the issue pipeline
  typedef enum logic [3:0] {
    FPTC_OP_NONE = 4'h0,
    FPTC_OP_ADD = 4'h1,
    FPTC_OP_SUB = 4'h2,
    FPTC_OP_MUL = 4'h3,
    FPTC_OP_DIV = 4'h4,
    FPTC_OP_MOVE = 4'h5,
    FPTC_OP_BARRIER = 4'h6
  } fptc_op_t;

  // operand class codes
  typedef enum logic [2:0] {
    FPTC_CL_ZERO = 3'h0,
    FPTC_CL_NORMAL = 3'h1,
    FPTC_CL_DENORM = 3'h2,
    FPTC_CL_INF = 3'h3,
    FPTC_CL_QNAN = 3'h4,
    FPTC_CL_SNAN = 3'h5
  } fptc_class_t;

  // trap delivery states, one-hot
  typedef enum logic [3:0] {
    FPTC_ST_IDLE = 4'h1,
    FPTC_ST_FW = 4'h2,
    FPTC_ST_OS = 4'h4,
    FPTC_ST_USER = 4'h8
  } fptc_state_t;

  // trap cause bit positions
  localparam int FPTC_CAUSE_W = 5;
  localparam int FPTC_CAUSE_INVALID = 0;
  localparam int FPTC_CAUSE_NONFIN = 1;
  localparam int FPTC_CAUSE_OVF = 2;
  localparam int FPTC_CAUSE_UNF = 3;
  localparam int FPTC_CAUSE_INEX = 4;

  localparam int FPTC_DATA_W = 64;
  localparam logic [FPTC_DATA_W-1:0] FPTC_POS_ZERO = 64'h0000000000000000;
  localparam logic [FPTC_DATA_W-1:0] FPTC_RESULT_RST = 64'h0000000000000000;
  localparam logic [FPTC_CAUSE_W-1:0] FPTC_CAUSE_RST = 5'h00;
  localparam logic [2:0] FPTC_PEND_RST = 3'h0;
  localparam logic [2:0] FPTC_PEND_MAX = 3'h7;

endpackage : fptc_pkg

// ==== core/fptc_trap_ctrl.sv ====
// floating-point exception detection, result override and trap signalling
// Functional notes
// - trap decisions come only from per-instruction qualifier bits, no control register.
// - without software qualifier, any non-finite operand or result traps and halts.
// - underflow with qualifier off writes +0 and takes no trap.
// - underflow with qualifier on writes true zero and traps.
// - software qualifier traps on non-finite cases; destination may be unpredictable.
// - inexact traps only when the inexact qualifier is present.
// - branch, load, store, copy-sign and conditional move never raise exceptions.
// - add/sub trap on denormal, infinite, NaN operands or opposite infinities summed.
// - add/sub always trap on exponent overflow.
// - multiply traps on denormal, infinite, NaN operands or zero times infinity.
// - multiply traps on overflow; underflow and inexact handled as for add.
// - divide traps on denormal, infinite, NaN operands, 0/0 or inf/inf.
// - negative-zero operands and results follow IEEE sign rules.
// - traps go to firmware, then os handler, then user handler, in order.
// - optionally, every disabled underflow may also trap to firmware.
`timescale 1ns/1ns
module fptc_trap_ctrl
  import fptc_pkg::*;
#(
  parameter bit UNF_ALWAYS_TRAP = 1'b0
)(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic issue_valid,
  output logic issue_ready,
  input wire fptc_op_t issue_op,
  input wire logic qual_sw,
  input wire logic qual_unf,
  input wire logic qual_inex,
  input wire fptc_class_t opa_class,
  input wire fptc_class_t opb_class,
  input wire logic opa_sign,
  input wire logic opb_sign,
  input wire logic res_overflow,
  input wire logic res_underflow,
  input wire logic res_inexact,
  input wire logic res_sign,
  input wire logic [FPTC_DATA_W-1:0] res_value,
  output logic wb_valid,
  output logic [FPTC_DATA_W-1:0] wb_value,
  output logic wb_unpredictable,
  output logic halt,
  input wire logic fw_ack,
  input wire logic os_ack,
  input wire logic user_ack,
  output logic fw_trap,
  output logic os_trap,
  output logic user_trap,
  output logic [FPTC_CAUSE_W-1:0] trap_cause
);
  fptc_dlv_if dlv ();
  logic is_arith;
  logic nonfin_in;
  logic invalid_in;
  logic unf_trap;
  logic [FPTC_CAUSE_W-1:0] cause_d;
  logic trap_d;
  logic take;
  logic [2:0] pend_q;
  logic barrier_hold;

  // true for the operand classes the hardware refuses to compute with
  function automatic logic nonfinite(input fptc_class_t c);
    nonfinite = (c == FPTC_CL_DENORM) || (c == FPTC_CL_INF) ||
                (c == FPTC_CL_QNAN) || (c == FPTC_CL_SNAN);
  endfunction : nonfinite

  function automatic logic is_zero(input fptc_class_t c);
    is_zero = (c == FPTC_CL_ZERO);
  endfunction : is_zero

  function automatic logic is_inf(input fptc_class_t c);
    is_inf = (c == FPTC_CL_INF);
  endfunction : is_inf

  // moves only shuffle bits, so they are kept out of every check below
  assign is_arith = (issue_op == FPTC_OP_ADD) || (issue_op == FPTC_OP_SUB) ||
                    (issue_op == FPTC_OP_MUL) || (issue_op == FPTC_OP_DIV);

  // per-operation input checks; they use operand classes and signs alone, no qualifiers
  always_comb begin
    nonfin_in = nonfinite(opa_class) || nonfinite(opb_class);
    invalid_in = 1'b0;
    unique case (issue_op)
      FPTC_OP_ADD: invalid_in = is_inf(opa_class) && is_inf(opb_class) &&
                                (opa_sign != opb_sign);
      FPTC_OP_SUB: invalid_in = is_inf(opa_class) && is_inf(opb_class) &&
                                (opa_sign == opb_sign);
      FPTC_OP_MUL: invalid_in = (is_zero(opa_class) && is_inf(opb_class)) ||
                                (is_inf(opa_class) && is_zero(opb_class));
      FPTC_OP_DIV: invalid_in = (is_zero(opa_class) && is_zero(opb_class)) ||
                                (is_inf(opa_class) && is_inf(opb_class));
      default: invalid_in = 1'b0;
    endcase
  end

  // underflow traps only when enabled, or always in the firmware-zero variant
  assign unf_trap = res_underflow && (qual_unf || UNF_ALWAYS_TRAP);

  // cause vector; output conditions are only meaningful with finite inputs
  always_comb begin
    cause_d = FPTC_CAUSE_RST;
    if (is_arith) begin
      cause_d[FPTC_CAUSE_INVALID] = invalid_in;
      cause_d[FPTC_CAUSE_NONFIN] = nonfin_in;
      cause_d[FPTC_CAUSE_OVF] = !nonfin_in && res_overflow;
      cause_d[FPTC_CAUSE_UNF] = !nonfin_in && unf_trap;
      cause_d[FPTC_CAUSE_INEX] = !nonfin_in && res_inexact && qual_inex;
    end
    trap_d = |cause_d;
  end

  // a barrier holds issue while a check is in flight or a trap is in delivery
  assign barrier_hold = (issue_op == FPTC_OP_BARRIER) &&
                        ((pend_q != FPTC_PEND_RST) || dlv.busy);
  // a new trap cannot be accepted until the previous delivery is done; the request
  // register is included so a second trap cannot slip in before the sequencer goes busy
  assign issue_ready = !barrier_hold && !dlv.busy && !dlv.req;
  assign take = issue_valid && issue_ready;

  // arithmetic ops in the final check stage, counted for the barrier
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      pend_q <= FPTC_PEND_RST;
    end else if (take && is_arith) begin
      pend_q <= FPTC_PEND_MAX >> 2;
    end else if (pend_q != FPTC_PEND_RST) begin
      pend_q <= pend_q - 3'h1;
    end
  end

  // registered trap request toward the delivery sequencer
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      dlv.req <= 1'b0;
      dlv.cause <= FPTC_CAUSE_RST;
    end else begin
      dlv.req <= take && trap_d;
      dlv.cause <= cause_d;
    end
  end

  // halt stands from a non-software non-finite trap until delivery finishes
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      halt <= 1'b0;
    end else if (take && is_arith && !qual_sw &&
                 (nonfin_in || invalid_in || res_overflow)) begin
      halt <= 1'b1;
    end else if (!dlv.busy && !dlv.req) begin
      halt <= 1'b0;
    end
  end

  // write-back value: true +0 on underflow, sign rules kept for zero results
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wb_valid <= 1'b0;
      wb_value <= FPTC_RESULT_RST;
      wb_unpredictable <= 1'b0;
    end else begin
      wb_valid <= take && is_arith;
      wb_unpredictable <= take && is_arith && qual_sw &&
                          (nonfin_in || invalid_in || res_overflow);
      if (take && is_arith) begin
        if (res_underflow && !nonfin_in) begin
          wb_value <= FPTC_POS_ZERO;
        end else begin
          // upstream delivers a correctly signed zero, e.g. -0 + -0 = -0
          wb_value <= {res_sign, res_value[FPTC_DATA_W-2:0]};
        end
      end
    end
  end

  fptc_deliver u_deliver (
    .core_clk(core_clk),
    .rstn(rstn),
    .dlv(dlv),
    .fw_ack(fw_ack),
    .os_ack(os_ack),
    .user_ack(user_ack),
    .fw_trap(fw_trap),
    .os_trap(os_trap),
    .user_trap(user_trap),
    .trap_cause(trap_cause)
  );
endmodule : fptc_trap_ctrl

// ==== test/fptc_handler_model.sv ====
// firmware, os and user handler layers that acknowledge traps in turn
`timescale 1ns/1ns
module fptc_handler_model (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic slow,
  input wire logic fw_trap,
  input wire logic os_trap,
  input wire logic user_trap,
  output logic fw_ack,
  output logic os_ack,
  output logic user_ack
);
  logic [2:0] wait_q;
  // each layer thinks briefly or long, then acks for one cycle only
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      wait_q <= 3'h0;
      {fw_ack, os_ack, user_ack} <= 3'h0;
    end else if (fw_ack || os_ack || user_ack || !(fw_trap || os_trap || user_trap)) begin
      wait_q <= 3'h0;
      {fw_ack, os_ack, user_ack} <= 3'h0;
    end else if (wait_q == (slow ? 3'h5 : 3'h0)) begin
      {fw_ack, os_ack, user_ack} <= {fw_trap, os_trap, user_trap};
    end else begin
      wait_q <= wait_q + 3'h1;
    end
  end
endmodule : fptc_handler_model

// ==== test/fptc_trap_ctrl_properties.sv ====
// port-level checks for the trap control block
`timescale 1ns/1ns
module fptc_trap_ctrl_properties
  import fptc_pkg::*;
#(
  parameter bit UNF_ALWAYS_TRAP = 1'b0
)(
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic issue_valid,
  input wire logic issue_ready,
  input wire fptc_op_t issue_op,
  input wire logic qual_sw,
  input wire logic qual_unf,
  input wire logic qual_inex,
  input wire fptc_class_t opa_class,
  input wire fptc_class_t opb_class,
  input wire logic res_overflow,
  input wire logic res_underflow,
  input wire logic res_inexact,
  input wire logic [FPTC_DATA_W-1:0] wb_value,
  input wire logic wb_unpredictable,
  input wire logic halt,
  input wire logic fw_ack,
  input wire logic fw_trap,
  input wire logic os_trap,
  input wire logic [FPTC_CAUSE_W-1:0] trap_cause
);
  logic acc;
  logic nrm;
  logic unf;
  // accepted arithmetic op; plain operands so output conditions are not masked
  assign acc = issue_valid && issue_ready && issue_op inside {[FPTC_OP_ADD:FPTC_OP_DIV]};
  assign nrm = opa_class == FPTC_CL_NORMAL && opb_class == FPTC_CL_NORMAL;
  assign unf = acc && nrm && res_underflow && !res_overflow;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rstn);
  move_quiet_a: assert property (
    issue_valid && issue_ready && issue_op == FPTC_OP_MOVE |=> !wb_unpredictable ##1 !fw_trap)
    else $error("move raised an exception");
  nonfin_halt_a: assert property (
    acc && !qual_sw && opa_class inside {[FPTC_CL_DENORM:FPTC_CL_SNAN]} |=> halt)
    else $error("non-finite operand did not halt");
  sw_unpred_a: assert property (
    acc && qual_sw && opa_class == FPTC_CL_QNAN |=> wb_unpredictable && !halt ##1 fw_trap)
    else $error("software mode trap wrong");
  unf_zero_a: assert property (unf |=> wb_value == FPTC_POS_ZERO)
    else $error("underflow result not plus zero");
  unf_quiet_a: assert property (
    unf && !qual_unf && !qual_inex && !UNF_ALWAYS_TRAP |-> ##2 !fw_trap)
    else $error("disabled underflow trapped");
  unf_trap_a: assert property (
    unf && qual_unf |-> ##2 fw_trap && trap_cause[FPTC_CAUSE_UNF])
    else $error("enabled underflow did not trap");
  inex_gate_a: assert property (
    acc && nrm && res_inexact && !res_overflow && !res_underflow
      |-> ##2 fw_trap == $past(qual_inex, 2))
    else $error("inexact trap not gated by qualifier");
  ovf_trap_a: assert property (
    acc && nrm && res_overflow |-> ##2 fw_trap && trap_cause[FPTC_CAUSE_OVF])
    else $error("overflow did not trap");
  fw_os_a: assert property (fw_trap && fw_ack |=> os_trap && !fw_trap)
    else $error("os layer did not follow firmware");
endmodule : fptc_trap_ctrl_properties
bind fptc_trap_ctrl fptc_trap_ctrl_properties #(.UNF_ALWAYS_TRAP(UNF_ALWAYS_TRAP)) u_props (.*);

// ==== test/fptc_trap_ctrl_tb.sv ====
// self-checking bench for the floating-point trap control block
`timescale 1ns/1ns
module fptc_trap_ctrl_tb;
  import fptc_pkg::*;
  localparam logic [FPTC_DATA_W-1:0] RV = 64'h3FF8000000000000;
  localparam fptc_class_t N = FPTC_CL_NORMAL;
  logic core_clk = 1'b0;
  logic rstn = 1'b0;
  logic slow = 1'b0;
  logic issue_valid = 1'b0;
  logic issue_ready, wb_valid, wb_unpredictable, halt, fw_ack, os_ack, user_ack;
  logic fw_trap, os_trap, user_trap;
  fptc_op_t issue_op = FPTC_OP_NONE;
  logic qual_sw = 1'b0, qual_unf = 1'b0, qual_inex = 1'b0, opa_sign = 1'b0, opb_sign = 1'b0;
  fptc_class_t opa_class = N, opb_class = N;
  logic res_overflow = 1'b0, res_underflow = 1'b0, res_inexact = 1'b0, res_sign = 1'b1;
  logic [FPTC_DATA_W-1:0] res_value = RV;
  logic [FPTC_DATA_W-1:0] wb_value;
  logic [FPTC_CAUSE_W-1:0] trap_cause;
  int fail_count = 0;
  int checked = 0;
  fptc_trap_ctrl u_fptc_trap_ctrl (.*);
  fptc_handler_model u_fptc_handler_model (.*);
  // 10 MHz core clock
  always #50 core_clk = ~core_clk;
  task automatic final_report();
    $display("checked=%0d fail_count=%0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : final_report
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  // rs = {opa_sign, opb_sign, overflow, underflow, inexact}; held until taken
  task automatic issue(input fptc_op_t op, input logic [2:0] q, input fptc_class_t ca,
                       input fptc_class_t cb, input logic [4:0] rs);
    logic rdy;
    int n;
    n = 0;
    issue_op <= op;
    {qual_sw, qual_unf, qual_inex} <= q;
    opa_class <= ca;
    opb_class <= cb;
    {opa_sign, opb_sign, res_overflow, res_underflow, res_inexact} <= rs;
    issue_valid <= 1'b1;
    do begin
      @(negedge core_clk);
      rdy = issue_ready;
      @(posedge core_clk);
      n++;
    end while (!rdy && n < 200);
    issue_valid <= 1'b0;
    chk(rdy, 1'b1);
  endtask : issue
  // one op end to end: writeback, trap cause, os and user layers reached, halt release
  task automatic run(input fptc_op_t op, input logic [2:0] q, input fptc_class_t ca,
                     input fptc_class_t cb, input logic [4:0] rs, input logic [4:0] ec,
                     input logic [1:0] hu);
    logic [1:0] seen;
    int n;
    seen = 2'h0;
    n = 0;
    issue(op, q, ca, cb, rs);
    @(negedge core_clk);
    chk({halt, wb_unpredictable}, hu);
    if (op inside {[FPTC_OP_ADD:FPTC_OP_DIV]}) begin
      chk(wb_valid, 1'b1);
      if (rs[1]) chk(wb_value, FPTC_POS_ZERO);
      else if (ec == 5'h00) chk(wb_value, {1'b1, RV[62:0]});
    end else begin
      // bit moves write nothing through the arithmetic path
      chk(wb_valid, 1'b0);
    end
    @(negedge core_clk);
    chk(fw_trap, ec != 5'h00);
    if (ec != 5'h00) chk(trap_cause, ec);
    while ((fw_trap || os_trap || user_trap || halt) && n < 100) begin
      seen |= {user_trap, os_trap};
      @(negedge core_clk);
      n++;
    end
    chk(seen, {2{ec != 5'h00}});
    chk(halt, 1'b0);
    @(posedge core_clk);
  endtask : run
  task automatic t_moves();
    run(FPTC_OP_MOVE, 3'h7, FPTC_CL_SNAN, FPTC_CL_INF, 5'h1F, 5'h00, 2'h0);
  endtask : t_moves
  task automatic t_nonfin();
    for (int i = 2; i < 6; i++) begin
      run(FPTC_OP_ADD, 3'h0, fptc_class_t'(i), N, 5'h00, 5'h02, 2'h2);
    end
    run(FPTC_OP_ADD, 3'h0, FPTC_CL_INF, FPTC_CL_INF, 5'h08, 5'h03, 2'h2);
    run(FPTC_OP_SUB, 3'h4, FPTC_CL_INF, FPTC_CL_INF, 5'h00, 5'h03, 2'h1);
    run(FPTC_OP_SUB, 3'h4, FPTC_CL_QNAN, N, 5'h00, 5'h02, 2'h1);
  endtask : t_nonfin
  task automatic t_unf_inex();
    run(FPTC_OP_ADD, 3'h0, N, N, 5'h1A, 5'h00, 2'h0);
    run(FPTC_OP_MUL, 3'h2, N, N, 5'h02, 5'h08, 2'h0);
    run(FPTC_OP_DIV, 3'h0, N, N, 5'h01, 5'h00, 2'h0);
    run(FPTC_OP_DIV, 3'h1, N, N, 5'h01, 5'h10, 2'h0);
    run(FPTC_OP_ADD, 3'h0, FPTC_CL_ZERO, FPTC_CL_ZERO, 5'h18, 5'h00, 2'h0);
  endtask : t_unf_inex
  task automatic t_invalid();
    run(FPTC_OP_MUL, 3'h0, FPTC_CL_ZERO, FPTC_CL_INF, 5'h00, 5'h03, 2'h2);
    run(FPTC_OP_DIV, 3'h0, FPTC_CL_ZERO, FPTC_CL_ZERO, 5'h00, 5'h01, 2'h2);
    run(FPTC_OP_DIV, 3'h0, FPTC_CL_INF, FPTC_CL_INF, 5'h00, 5'h03, 2'h2);
  endtask : t_invalid
  task automatic t_ovf();
    slow <= 1'b1;
    for (int i = 1; i < 4; i++) begin
      run(fptc_op_t'(i), 3'h3, N, N, 5'h04, 5'h04, 2'h2);
    end
  endtask : t_ovf
  task automatic t_barrier();
    issue(FPTC_OP_DIV, 3'h0, FPTC_CL_SNAN, N, 5'h00);
    @(negedge core_clk);
    @(negedge core_clk);
    chk(fw_trap, 1'b1);
    @(posedge core_clk);
    issue(FPTC_OP_BARRIER, 3'h0, N, N, 5'h00);
    @(negedge core_clk);
    chk({fw_trap, os_trap, user_trap}, 3'h0);
    @(posedge core_clk);
  endtask : t_barrier
  // main sequence: reset held 12 cycles, then every scenario in turn
  initial begin
    repeat (12) @(posedge core_clk);
    rstn <= 1'b1;
    @(posedge core_clk);
    t_moves();
    t_nonfin();
    t_unf_inex();
    t_invalid();
    t_ovf();
    t_barrier();
    final_report();
  end
  // watchdog well beyond the few hundred cycles the scenarios need
  initial begin
    repeat (5000) @(posedge core_clk);
    fail_count++;
    final_report();
  end
endmodule : fptc_trap_ctrl_tb
